// ==== hdl/image_path_routing.sv ====
/*
  Image path routing for the camera front end: mode routing of the capture
  controller and scaler unit (capture-to-resizer and preview engine mode bits are only stored), resizer pass sequencing,
  slice arithmetic and a register port with interrupt.
  Assumes a plain register master; software sequences passes per interrupt.
*/
// The address-and-strobe port and the placing of the registers were left to the implementer.
`include "image_path_defs.svh"
`default_nettype none
module image_path_routing #(
  parameter int PIX_W = 10,
  parameter int DIM_W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic [PIX_W-1:0] rawPixel,
  input wire logic rawValid,
  input wire logic memPixelReady,
  output logic [PIX_W-1:0] videoPortPixel,
  output logic videoPortValid,
  output logic [PIX_W-1:0] captureMemPixel,
  output logic captureMemValid,
  output logic resizerFromMemory,
  output logic resizerBusy,
  output logic resizerPixelStrobe,
  output logic irq
);
  logic [7:0] control_r;
  logic [7:0] horizontal_scale_ratio_r;
  logic [7:0] vertical_scale_ratio_r;
  logic [DIM_W-1:0] passPixels_r;
  logic [DIM_W-1:0] outWidth_r;
  logic [3:0] filters_r;
  logic [31:0] resizer_memory_input_address_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [31:0] rdData_r;
  image_path_pkg::pass_state_t state_r;
  logic selLatched_r;
  logic [7:0] hRatioLatched_r;
  logic [7:0] vRatioLatched_r;
  logic [DIM_W-1:0] pixCount_r;
  logic [PIX_W-1:0] vpPix_r;
  logic vpValid_r;
  logic [PIX_W-1:0] memPix_r;
  logic memValid_r;
  logic [4:0] trimPixels;
  logic [3:0] trimLines;
  logic pixelStrobe;
  logic startReq;
  logic passDone;
  logic ratioBad;
  logic widthBad;
  logic [DIM_W-1:0] sliceCount;
  logic [DIM_W-1:0] sliceStep;
  logic [2:0] events;

  function automatic logic ratio_ok(input logic [7:0] r);
    ratio_ok = (r >= `RATIO_MIN) && ({1'b0, r} <= `RATIO_MAX);
  endfunction

  assign startReq = regWr && (regAddr == `ADDR_CONTROL) && regWrData[`CTL_START] && (state_r == image_path_pkg::PASS_IDLE);
  // reject ratios outside one pass range
  assign ratioBad = !ratio_ok(horizontal_scale_ratio_r) || !ratio_ok(vertical_scale_ratio_r);
  assign widthBad = (passPixels_r > `SLICE_WIDTH);
  assign sliceCount = (outWidth_r == '0) ? '0 : (outWidth_r - 1'b1) / `SLICE_WIDTH + 1'b1;
  assign sliceStep = DIM_W'(`SLICE_WIDTH);

  // register writes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      control_r <= 8'h00;
      horizontal_scale_ratio_r <= `RATIO_ONE;
      vertical_scale_ratio_r <= `RATIO_ONE;
      passPixels_r <= '0;
      outWidth_r <= '0;
      filters_r <= 4'h0;
      resizer_memory_input_address_r <= 32'h0000_0000;
      mask_r <= 3'h0;
    end
    else if (regWr)
    begin
      case (regAddr)
        `ADDR_CONTROL: control_r <= {regWrData[7:1], 1'b0};
        `ADDR_SCALE:
        begin
          horizontal_scale_ratio_r <= regWrData[7:0];
          vertical_scale_ratio_r <= regWrData[15:8];
        end
        `ADDR_SIZE:
        begin
          passPixels_r <= regWrData[DIM_W-1:0];
          outWidth_r <= regWrData[DIM_W+15:16];
        end
        `ADDR_FILTERS: filters_r <= regWrData[3:0];
        `ADDR_MASK: mask_r <= regWrData[2:0];
        `ADDR_MEMADDR: resizer_memory_input_address_r <= regWrData;
        default: ;
      endcase
    end
  end

  // latch pass settings at start only
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      selLatched_r <= 1'b0;
      hRatioLatched_r <= `RATIO_ONE;
      vRatioLatched_r <= `RATIO_ONE;
    end
    // refused starts must not move the selector
    else if (startReq && !ratioBad && !widthBad)
    begin
      selLatched_r <= regWrData[`CTL_SELECT];
      hRatioLatched_r <= horizontal_scale_ratio_r;
      vRatioLatched_r <= vertical_scale_ratio_r;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= image_path_pkg::PASS_IDLE;
      pixCount_r <= '0;
    end
    else
    begin
      case (state_r)
        image_path_pkg::PASS_IDLE:
          if (startReq && !ratioBad && !widthBad)
          begin
            pixCount_r <= '0;
            // selector zero is the live pass, one is memory
            state_r <= regWrData[`CTL_SELECT] ? image_path_pkg::PASS_MEMORY : image_path_pkg::PASS_LIVE;
          end
        image_path_pkg::PASS_LIVE, image_path_pkg::PASS_MEMORY:
          if (pixelStrobe && (state_r == image_path_pkg::PASS_LIVE || memPixelReady))
          begin
            pixCount_r <= pixCount_r + 1'b1;
            if (pixCount_r + 1'b1 >= passPixels_r)
              state_r <= image_path_pkg::PASS_IDLE;
          end
        default: state_r <= image_path_pkg::PASS_IDLE;
      endcase
    end
  end

  assign passDone = (state_r != image_path_pkg::PASS_IDLE) && pixelStrobe
    && (state_r == image_path_pkg::PASS_LIVE || memPixelReady) && (pixCount_r + 1'b1 >= passPixels_r);
  assign events = {startReq && widthBad, startReq && ratioBad, passDone};

  // sticky status, set wins over write-one clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      status_r <= 3'h0;
    else
      status_r <= (status_r & ~((regWr && regAddr == `ADDR_STATUS) ? regWrData[2:0] : 3'h0)) | events;
  end

  assign irq = |(status_r & mask_r);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vpPix_r <= '0;
      vpValid_r <= 1'b0;
      memPix_r <= '0;
      memValid_r <= 1'b0;
    end
    else
    begin
      vpValid_r <= rawValid && control_r[`CTL_VPORT];
      if (rawValid && control_r[`CTL_VPORT])
        vpPix_r <= rawPixel;
      memValid_r <= rawValid && control_r[`CTL_CAPWR];
      if (rawValid && control_r[`CTL_CAPWR])
        memPix_r <= rawPixel;
    end
  end

  assign videoPortPixel = vpPix_r;
  assign videoPortValid = vpValid_r;
  assign captureMemPixel = memPix_r;
  assign captureMemValid = memValid_r;
  assign resizerFromMemory = selLatched_r;
  assign resizerBusy = (state_r != image_path_pkg::PASS_IDLE);
  assign resizerPixelStrobe = pixelStrobe && (state_r == image_path_pkg::PASS_LIVE || memPixelReady);

  // reads, data one cycle later
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdData_r <= 32'h0000_0000;
    else if (regRd)
    begin
      case (regAddr)
        `ADDR_CONTROL: rdData_r <= {23'h0, resizerBusy, control_r};
        `ADDR_SCALE: rdData_r <= {vRatioLatched_r, hRatioLatched_r, vertical_scale_ratio_r, horizontal_scale_ratio_r};
        `ADDR_SIZE: rdData_r <= {outWidth_r, passPixels_r};
        `ADDR_FILTERS: rdData_r <= {19'h0, trimLines, trimPixels, filters_r};
        `ADDR_STATUS: rdData_r <= {29'h0, status_r};
        `ADDR_MASK: rdData_r <= {29'h0, mask_r};
        `ADDR_RESULT: rdData_r <= {sliceStep, sliceCount};
        `ADDR_MEMADDR: rdData_r <= resizer_memory_input_address_r;
        default: rdData_r <= 32'h0000_0000;
      endcase
    end
    else
      rdData_r <= 32'h0000_0000;
  end

  assign regRdData = rdData_r;

  pass_pacer u_pacer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .fromMemory(selLatched_r),
    .active(resizerBusy),
    .liveValid(rawValid),
    .pixelStrobe(pixelStrobe)
  );

  edge_trim_calc u_trim (
    .medianOn(filters_r[0]),
    .noiseOn(filters_r[1]),
    .cfaOn(filters_r[2]),
    .chromaOn(filters_r[3]),
    .trimPixels(trimPixels),
    .trimLines(trimLines)
  );
endmodule
`default_nettype wire

// ==== hdl/image_path_defs.svh ====
/*
  Shared constants for the image path routing block: register offsets,
  field positions, reset values and processing limits.
  Assumes inclusion by bare name from design files.
*/
`ifndef IMAGE_PATH_DEFS_SVH
`define IMAGE_PATH_DEFS_SVH

`define ADDR_CONTROL 4'h0
`define ADDR_SCALE 4'h1
`define ADDR_SIZE 4'h2
`define ADDR_FILTERS 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_MASK 4'h5
`define ADDR_RESULT 4'h6
`define ADDR_MEMADDR 4'h7

`define CTL_START 0
`define CTL_SELECT 1
`define CTL_VPORT 2
`define CTL_CAPWR 3
`define CTL_CAP2RSZ 4
`define CTL_PRVSRC 5
`define CTL_PRVRSZ 6
`define CTL_PRVMEM 7

`define STS_DONE 0
`define STS_RATIO_ERR 1
`define STS_WIDTH_ERR 2

`define RATIO_ONE 8'h40
`define RATIO_MIN 8'h10
`define RATIO_MAX 9'h100
`define SLICE_WIDTH 16'h0500
`define TRIM_MEDIAN 5'h04
`define TRIM_NOISE 5'h04
`define TRIM_CFA 5'h04
`define TRIM_CHROMA 5'h02
`define LINES_NOISE 4'h4
`define LINES_CFA 4'h4
`define DMA_HALF_DIV 1'h1

`endif

// ==== hdl/image_path_pkg.sv ====
/*
  Types for the image path routing block.
  Assumes the defs header carries every numeric constant.
*/
`default_nettype none
package image_path_pkg;
  typedef enum logic [1:0] {PASS_IDLE, PASS_LIVE, PASS_MEMORY} pass_state_t;
endpackage
`default_nettype wire

// ==== hdl/edge_trim_calc.sv ====
/*
  Edge trim calculator: pixels and lines lost by the enabled preview filters.
  Assumes filter enables are static while a slice is processed.
*/
`include "image_path_defs.svh"
`default_nettype none
module edge_trim_calc (
  input wire logic medianOn,
  input wire logic noiseOn,
  input wire logic cfaOn,
  input wire logic chromaOn,
  output logic [4:0] trimPixels,
  output logic [3:0] trimLines
);
  always_comb
  begin
    trimPixels = (medianOn ? `TRIM_MEDIAN : 5'h00) + (noiseOn ? `TRIM_NOISE : 5'h00)
               + (cfaOn ? `TRIM_CFA : 5'h00) + (chromaOn ? `TRIM_CHROMA : 5'h00);
    trimLines = (noiseOn ? `LINES_NOISE : 4'h0) + (cfaOn ? `LINES_CFA : 4'h0);
  end
endmodule
`default_nettype wire

// ==== hdl/pass_pacer.sv ====
/*
  Pass pacer: emits a pixel strobe per live pixel, or every second
  clock when the resizer reads from memory.
  Assumes live pixels arrive as a valid strobe on the same clock.
*/
`include "image_path_defs.svh"
`default_nettype none
module pass_pacer (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic fromMemory,
  input wire logic active,
  input wire logic liveValid,
  output logic pixelStrobe
);
  logic phase_r;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_r <= 1'b0;
    else if (active && fromMemory)
      phase_r <= phase_r ^ `DMA_HALF_DIV;
    else
      phase_r <= 1'b0;
  end

  assign pixelStrobe = active && (fromMemory ? phase_r : liveValid);
endmodule
`default_nettype wire

// ==== dv/image_path_routing_sva.sv ====
/*
  Port checker for the image path routing block.
  Assumes a bind to the top module and a single clock domain.
*/
`default_nettype none
module image_path_routing_sva #(
  parameter int PIX_W = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic [PIX_W-1:0] rawPixel,
  input wire logic rawValid,
  input wire logic memPixelReady,
  input wire logic [PIX_W-1:0] videoPortPixel,
  input wire logic videoPortValid,
  input wire logic resizerFromMemory,
  input wire logic resizerBusy,
  input wire logic resizerPixelStrobe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_memPix;
    resizerPixelStrobe && resizerFromMemory;
  endsequence
  sequence s_livePix;
    resizerPixelStrobe && !resizerFromMemory;
  endsequence
  property p_video;
    videoPortValid |-> $past(rawValid) && videoPortPixel == $past(rawPixel);
  endproperty
  a_video: assert property (p_video) else $error("video port copy wrong");
  property p_rdIdle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_select;
    $changed(resizerFromMemory) |-> $rose(resizerBusy);
  endproperty
  a_select: assert property (p_select) else $error("selector moved mid pass");
  property p_strobeBusy;
    resizerPixelStrobe |-> resizerBusy;
  endproperty
  a_strobeBusy: assert property (p_strobeBusy) else $error("pixel outside pass");
  property p_memGap;
    s_memPix |=> !resizerPixelStrobe;
  endproperty
  a_memGap: assert property (p_memGap) else $error("memory pass too fast");
  property p_live;
    s_livePix |-> rawValid;
  endproperty
  a_live: assert property (p_live) else $error("live pixel without valid");
  property p_memReady;
    s_memPix |-> memPixelReady;
  endproperty
  a_memReady: assert property (p_memReady) else $error("memory pixel not ready");
  property p_end;
    $fell(resizerBusy) |-> $past(resizerPixelStrobe);
  endproperty
  a_end: assert property (p_end) else $error("pass ended without pixel");
endmodule
bind image_path_routing image_path_routing_sva #(.PIX_W(PIX_W)) i_sva (.*);
`default_nettype wire

// ==== dv/sensor_memory_model.sv ====
/*
  Far side model: raw sensor pixels and memory pixel availability.
  Assumes enables from the bench on the same clock.
*/
`default_nettype none
module sensor_memory_model (
  input wire logic ref_clk,
  input wire logic liveOn,
  input wire logic memOn,
  output var logic [9:0] rawPixel,
  output var logic rawValid,
  output var logic memPixelReady
);
  int seed = 32'hD9943931;
  initial
  begin
    rawPixel = 10'h155;
    rawValid = 1'b0;
    memPixelReady = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    // live pixel pacing; bus inverted when idle
    rawValid <= liveOn && !rawValid;
    rawPixel <= (liveOn && !rawValid) ? 10'($random(seed)) : ~rawPixel;
    memPixelReady <= memOn && ($random(seed) % 4 != 0);
  end
endmodule
`default_nettype wire

// ==== dv/image_path_routing_tb_top.sv ====
/*
  Self-checking bench for the image path routing block.
  Assumes the checker binds itself and the far side model drives pixels.
*/
`default_nettype none
module image_path_routing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic liveOn = 1'b0;
  logic memOn = 1'b0;
  logic [31:0] regRdData;
  logic [9:0] rawPixel, videoPortPixel, captureMemPixel;
  logic rawValid, memPixelReady, videoPortValid, captureMemValid;
  logic resizerFromMemory, resizerBusy, resizerPixelStrobe, irq;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'hD9943931;
  int strobes = 0;
  int wid[5] = '{1, 1280, 1281, 3186, 65535};
  logic [9:0] vq[$];
  logic [7:0] ctlExp = 8'h00;
  logic lastRaw = 1'b0;
  always #10 ref_clk = ~ref_clk;
  sensor_memory_model i_far (.*);
  image_path_routing i_dut (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task automatic report_and_stop();
  begin
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
  begin
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    if (a == 4'h0)
      ctlExp <= d[7:0];
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string n);
  begin
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, regRdData);
    @(posedge ref_clk);
  end
  endtask
  // pixel model: forwarded raw pixels one cycle later
  always @(negedge ref_clk)
  begin
    chk("video valid", 32'(lastRaw && ctlExp[2]), 32'(videoPortValid));
    chk("capture valid", 32'(lastRaw && ctlExp[3]), 32'(captureMemValid));
    if (videoPortValid === 1'b1)
      chk("video pixel", 32'(vq[0]), 32'(videoPortPixel));
    if (captureMemValid === 1'b1)
      chk("capture pixel", 32'(vq[0]), 32'(captureMemPixel));
    if (videoPortValid === 1'b1 || captureMemValid === 1'b1)
      void'(vq.pop_front());
    if (rawValid === 1'b1 && (ctlExp[2] || ctlExp[3]))
      vq.push_back(rawPixel);
    lastRaw <= (rawValid === 1'b1);
    if (resizerPixelStrobe === 1'b1)
      strobes++;
  end
  task automatic run_pass(input logic sel, input logic [15:0] n, input logic [15:0] r);
    int k;
    logic [31:0] a;
  begin
    // live pass needs input address zero
    a = sel ? ($random(seed) & 32'hFFFF_FFF0) : 32'h0;
    wr(4'h7, a);
    rdchk(4'h7, a, "input address");
    wr(4'h1, {16'h0, r});
    wr(4'h2, {16'h0, n});
    strobes = 0;
    wr(4'h0, {28'h0, !sel, !sel, sel, 1'b1});
    liveOn <= !sel;
    memOn <= sel;
    // restart and new ratios while busy stay unused
    wr(4'h0, {28'h0, !sel, !sel, !sel, 1'b1});
    wr(4'h1, 32'h4040);
    for (k = 0; k < 8000; k++)
    begin
      @(negedge ref_clk);
      if (resizerBusy === 1'b0)
        break;
    end
    @(posedge ref_clk);
    liveOn <= 1'b0;
    memOn <= 1'b0;
    if (k == 8000)
      bad_count++;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("busy", 32'h0, 32'(resizerBusy));
    chk("pixels", 32'(n), 32'(strobes));
    chk("selector", 32'(sel), 32'(resizerFromMemory));
    @(posedge ref_clk);
    rdchk(4'h1, {r, 16'h4040}, "latched ratios");
    rdchk(4'h4, 32'h1, "done");
    wr(4'h5, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    wr(4'h4, 32'h1);
    chk("irq clear", 32'h0, 32'(irq));
  end
  endtask
  initial
  begin
    int p;
    int l;
    logic [31:0] d;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdchk(4'h1, 32'h4040_4040, "scale reset");
    wr(4'h9, 32'hFFFF);
    rdchk(4'h9, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++)
    begin
      p = (i[3] ? 2 : 0) + 4 * (i[0] + i[1] + i[2]);
      l = 4 * (i[1] + i[2]);
      wr(4'h3, 32'(i));
      rdchk(4'h3, 32'(i + 16 * p + 512 * l), "trim");
    end
    // step 1280, same as the slice width, so slices do not overlap
    foreach (wid[j])
    begin
      wr(4'h2, {16'(wid[j]), 16'h0});
      rdchk(4'h6, {16'h0500, 16'((wid[j] - 1) / 1280 + 1)}, "slices");
    end
    wr(4'h1, 32'h0F40);
    wr(4'h2, 32'h4);
    wr(4'h0, 32'h1);
    rdchk(4'h4, 32'h2, "ratio error");
    wr(4'h5, 32'h2);
    chk("irq error", 32'h1, 32'(irq));
    wr(4'h5, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    wr(4'h4, 32'h2);
    wr(4'h1, 32'h4040);
    wr(4'h2, 32'h0501);
    wr(4'h0, 32'h1);
    rdchk(4'h4, 32'h4, "width error");
    wr(4'h4, 32'h4);
    run_pass(1'b0, 16'h0008, 16'h1010);
    run_pass(1'b1, 16'h0500, 16'hFFFF);
    for (int j = 0; j < 4; j++)
    begin
      d = (j == 0) ? 32'h08 : (j == 1) ? 32'h44 : (j == 2) ? 32'hA0 : ($random(seed) & 32'hFE);
      wr(4'h0, d);
      liveOn <= (j < 2);
      repeat (8) @(posedge ref_clk);
      liveOn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rdchk(4'h0, d, "routing");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
